// file: common/sbrg_pkg.sv
// Purpose: constants for the serial baud rate generator
// Assumes: 250 MHz ref_clk, Avalon-MM slave with 32-bit data
// Notes: bit_rate_select sits at word offset 0x0
package sbrg_pkg;
  localparam logic [1:0] ADDR_BIT_RATE_SELECT = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [7:0] BIT_RATE_SELECT_RESET = 8'h00;
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 2;
  localparam int PRE_LSB = 4;
  localparam int PRE_MSB = 5;
  localparam logic [7:0] BIT_RATE_SELECT_MASK = 8'h37;
  localparam logic [3:0] PD_CODE0 = 4'h1;
  localparam logic [3:0] PD_CODE1 = 4'h3;
  localparam logic [3:0] PD_CODE2 = 4'h4;
  localparam logic [3:0] PD_CODE3 = 4'hD;
  // sample tick is 16x bit rate, so 64 = 4 x 16
  localparam logic [3:0] FIXED_PRE_DIV = 4'h4;
  localparam logic [3:0] SAMPLES_PER_BIT = 4'hF;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [31:0] READDATA_RESET = 32'h0000_0000;
  localparam logic [7:0] BD_UNIT = 8'h01;
  localparam logic WAIT_IDLE = 1'b1;
endpackage

// file: src/sbrg_top.sv
// Purpose: baud rate generator; divides the baud clock into sample and bit ticks
// Assumes: baud clock enable arrives as a one-cycle pulse synchronous to ref_clk
// Notes: one-cycle wait state on every bus access
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
module sbrg_top (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic selected_source_clock,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic sample_tick,
  output logic bit_tick
);
  function automatic logic [3:0] pd_limit(input logic [1:0] code);
    case (code)
      2'h0: pd_limit = sbrg_pkg::PD_CODE0;
      2'h1: pd_limit = sbrg_pkg::PD_CODE1;
      2'h2: pd_limit = sbrg_pkg::PD_CODE2;
      default: pd_limit = sbrg_pkg::PD_CODE3;
    endcase
  endfunction

  // zero-extend a register onto the data bus
  function automatic logic [31:0] widen_byte(input logic [7:0] value);
    widen_byte = {24'h000000, value};
  endfunction

  function automatic logic [31:0] widen_nibble(input logic [3:0] value);
    widen_nibble = {28'h0000000, value};
  endfunction

  // stage terminal count; >= lets a shorter divisor act at once
  function automatic logic reached(input logic [7:0] count, input logic [7:0] limit);
    reached = (count >= limit - sbrg_pkg::BD_UNIT);
  endfunction

  typedef enum logic {
    SBRG_BUS_IDLE = 1'b0,
    SBRG_BUS_ANSWER = 1'b1
  } sbrg_bus_state_type;

  sbrg_bus_state_type bus_state;
  sbrg_bus_state_type next_bus_state;
  logic [7:0] bit_rate_select;
  logic [1:0] fixed_cnt;
  logic [3:0] pd_cnt;
  logic [6:0] bd_cnt;
  logic [3:0] sample_cnt;

  // settings decode
  wire logic [1:0] prescaler_select = bit_rate_select[sbrg_pkg::PRE_MSB:sbrg_pkg::PRE_LSB];
  wire logic [2:0] rate_divisor_select = bit_rate_select[sbrg_pkg::RATE_MSB:sbrg_pkg::RATE_LSB];
  wire logic [3:0] prescaler_divisor = pd_limit(prescaler_select);
  wire logic [7:0] rate_divisor = sbrg_pkg::BD_UNIT << rate_divisor_select;

  // bus decode
  wire logic ack = (bus_state == SBRG_BUS_ANSWER);
  wire logic req = (avs_read | avs_write) & ~ack;
  wire logic addr_rate = (avs_address == sbrg_pkg::ADDR_BIT_RATE_SELECT);
  wire logic addr_status = (avs_address == sbrg_pkg::ADDR_STATUS);
  // write lands at the edge where the master sees waitrequest low
  wire logic wr_sel = avs_write & ack & addr_rate & avs_byteenable[0];
  wire logic [31:0] rd_value = addr_rate ? widen_byte(bit_rate_select) :
    addr_status ? widen_nibble(sample_cnt) : sbrg_pkg::UNMAPPED_READ;
  wire logic [31:0] next_avs_readdata = (req & avs_read) ? rd_value : avs_readdata;
  wire logic [7:0] next_bit_rate_select =
    wr_sel ? (avs_writedata[7:0] & sbrg_pkg::BIT_RATE_SELECT_MASK) : bit_rate_select;

  // chain: /4 -> /PD -> /BD gives 16x bit rate
  wire logic fixed_done = selected_source_clock & (fixed_cnt == 2'(sbrg_pkg::FIXED_PRE_DIV - 4'h1));
  wire logic pd_done = fixed_done & reached({4'h0, pd_cnt}, {4'h0, prescaler_divisor});
  wire logic bd_done = pd_done & reached({1'b0, bd_cnt}, rate_divisor);
  wire logic bit_done = bd_done & (sample_cnt == sbrg_pkg::SAMPLES_PER_BIT);
  wire logic [1:0] next_fixed_cnt = selected_source_clock ? fixed_cnt + 2'h1 : fixed_cnt;
  wire logic [3:0] next_pd_cnt = pd_done ? 4'h0 : (fixed_done ? pd_cnt + 4'h1 : pd_cnt);
  wire logic [6:0] next_bd_cnt = bd_done ? 7'h00 : (pd_done ? bd_cnt + 7'h01 : bd_cnt);
  wire logic [3:0] next_sample_cnt = bd_done ? sample_cnt + 4'h1 : sample_cnt;

  // one wait state per access
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      SBRG_BUS_IDLE: begin
        if (avs_read | avs_write) begin
          next_bus_state = SBRG_BUS_ANSWER;
        end
      end
      SBRG_BUS_ANSWER: begin
        next_bus_state = SBRG_BUS_IDLE;
      end
      default: begin
        next_bus_state = SBRG_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state <= SBRG_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_rate_select <= sbrg_pkg::BIT_RATE_SELECT_RESET;
    end else begin
      bit_rate_select <= next_bit_rate_select;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= sbrg_pkg::READDATA_RESET;
    end else begin
      avs_readdata <= next_avs_readdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= sbrg_pkg::WAIT_IDLE;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fixed_cnt <= 2'h0;
    end else begin
      fixed_cnt <= next_fixed_cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pd_cnt <= 4'h0;
    end else begin
      pd_cnt <= next_pd_cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bd_cnt <= 7'h00;
    end else begin
      bd_cnt <= next_bd_cnt;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_cnt <= 4'h0;
    end else begin
      sample_cnt <= next_sample_cnt;
    end
  end

  // both ticks come from the one chain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= bd_done;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= bit_done;
    end
  end
endmodule

// file: verification/sbrg_assertions.sv
// Purpose: port checks for sbrg_top
// Assumes: ticks are one-cycle pulses
// Notes: bound after the module
`timescale 1ns/1ns
module sbrg_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic selected_source_clock,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sample_tick,
  input wire logic bit_tick
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire req = avs_read || avs_write;
  rate_shared_a: assert property (bit_tick |-> sample_tick) else $error("bit tick alone");
  sample_gap_a: assert property (sample_tick |=> !sample_tick [*3]) else $error("sample gap");
  bit_gap_a: assert property (bit_tick |=> !bit_tick [*8]) else $error("bit gap");
  tick_src_a: assert property ($rose(sample_tick) |-> $past(selected_source_clock)) else $error("no baud");
  mask_read_a: assert property (req && !avs_waitrequest && avs_read && avs_address == 2'h0
    |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[3]) else $error("mask");
  unmapped_zero_a: assert property (!avs_waitrequest && avs_read && avs_address[1] |-> avs_readdata == 32'h0)
    else $error("unmapped");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
  wait_back_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait back");
  cover property (bit_tick);
  cover property (req && !avs_waitrequest && avs_write);
  cover property (!avs_waitrequest && avs_address == 2'h2);
endmodule
bind sbrg_top sbrg_chk chk (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .selected_source_clock(selected_source_clock),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .sample_tick(sample_tick),
  .bit_tick(bit_tick)
);

// file: verification/sbrg_top_tb.sv
// Purpose: self-checking bench for sbrg_top
// Assumes: random baud clock enable
// Notes: bit period counted in enable cycles
`timescale 1ns/1ns
module sbrg_top_tb;
  logic ref_clk = 0, arst_n = 0, selected_source_clock = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [1:0] avs_address = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 0, avs_readdata, rd;
  logic sample_tick, bit_tick;
  logic [7:0] cfg;
  integer seed = 32'h4984, failures = 0, cmp_count = 0, n, s, i, pd[4] = '{1, 3, 4, 13};
  sbrg_top DUT (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .selected_source_clock(selected_source_clock),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sample_tick(sample_tick),
    .bit_tick(bit_tick)
  );
  initial forever #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) selected_source_clock <= (($random(seed) & 7) != 0);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 24'h0, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge ref_clk);
  endtask
  task measure;
    while (bit_tick !== 1'b1) @(posedge ref_clk);
    n = 0;
    s = 0;
    do begin
      n += selected_source_clock;
      s += sample_tick;
      @(posedge ref_clk);
    end while (bit_tick !== 1'b1);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    bus(1, 2'h2, 8'h37);
    bus(0, 2'h0, 8'h0);
    chk(rd, 32'h0);
    bus(0, 2'h2, 8'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 12; i++) begin
      cfg = $random(seed);
      // every prescaler code at short rates, then every rate code at prescaler 1
      cfg[5:4] = (i < 4) ? i[1:0] : 2'h0;
      cfg[2:0] = (i < 4) ? {2'h0, cfg[0]} : 3'(i - 4);
      bus(1, 2'h0, cfg);
      bus(0, 2'h0, 8'h0);
      chk(rd, {24'h0, cfg & 8'h37});
      measure;
      measure;
      chk(n, 64 * pd[cfg[5:4]] * (1 << cfg[2:0]));
      chk(s, 16);
      $display("setting %h done", cfg);
    end
    avs_byteenable <= 4'hE;
    bus(1, 2'h0, ~cfg);
    avs_byteenable <= 4'hF;
    bus(0, 2'h0, 8'h0);
    chk(rd, {24'h0, cfg & 8'h37});
    arst_n <= 0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1;
    @(posedge ref_clk);
    bus(0, 2'h1, 8'h0);
    chk(rd, 32'h0);
    bus(0, 2'h0, 8'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    stop_test;
  end
endmodule
